/* rtl/aics_map.svh */
// Summary of operation
// - opcode 06h returns the device to defaults; host sends it once after power-up.
// - opcode 40h plus one byte writes the configuration; continuous gain four is 12h.
// - opcode 20h makes the device return the current configuration byte.
// - opcode 08h in continuous mode starts back to back conversions.
// - result_ready_n goes low on each new result; host reads on the falling edge.
// - opcode 10h returns the latest conversion result as exactly three bytes.
// - opcode 02h halts conversions and enters the low power state.
// - input_select_field 111 shorts both converter inputs at mid-supply for offset.
// - code scales as input over reference times gain, saturating at full scale.
// - at 90 SPS every conversion takes about 11.3 ms.
// - configuration holds gain four and single-shot or continuous mode; defaults are gain four off and single-shot.
// - the device never pulls the serial clock line low.
// - result_ready_n is open drain, pulling low only.
`ifndef AICS_MAP_SVH
`define AICS_MAP_SVH
// ----------------------------------------
// wishbone register offsets
// ----------------------------------------
`define AICS_REG_STATUS   8'h00
`define AICS_REG_CONFIG   8'h04
`define AICS_REG_RESULT   8'h08
`define AICS_REG_DEVADDR  8'h0C
// ----------------------------------------
// opcodes
// ----------------------------------------
`define AICS_OP_RESET     8'h06
`define AICS_OP_CFG_WR    8'h40
`define AICS_OP_CFG_RD    8'h20
`define AICS_OP_START     8'h08
`define AICS_OP_RESULT    8'h10
`define AICS_OP_SLEEP     8'h02
// ----------------------------------------
// configuration fields and reset values
// ----------------------------------------
`define AICS_CFG_SEL_HI   7
`define AICS_CFG_SEL_LO   5
`define AICS_CFG_GAIN     4
`define AICS_CFG_CONT     1
`define AICS_CFG_RST      8'h00
`define AICS_SEL_SHORT    3'h7
`define AICS_DEVADDR_RST  7'h40
`define AICS_CODE_MAX     24'h7FFFFF
`define AICS_CODE_MIN     24'h800000
`define AICS_FILL_BYTE    8'hFF
// ----------------------------------------
// timing
// ----------------------------------------
`define AICS_CLK_NS       5
`define AICS_POR_US       500
`define AICS_CONV_US      11300
`define AICS_POR_CYCLES   (`AICS_POR_US * 1000 / `AICS_CLK_NS)
`define AICS_CONV_CYCLES  (`AICS_CONV_US * 1000 / `AICS_CLK_NS)
`endif

/* rtl/aics_pkg.sv */
package aics_pkg;
	typedef enum logic [2:0] {
		AICS_IDLE,
		AICS_RX,
		AICS_ACK,
		AICS_LOAD,
		AICS_TX,
		AICS_MACK
	} aics_state_t;
	typedef logic [7:0] aics_byte_t;
endpackage

/* rtl/aics_top.sv */
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "aics_map.svh"
module aics_top
	import aics_pkg::*;
#(
	parameter int POR_CYCLES  = `AICS_POR_CYCLES,
	parameter int CONV_CYCLES = `AICS_CONV_CYCLES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	output var  logic        SDA_OUT,
	output var  logic        SDA_OE,
	output var  logic        RESULT_READY_N_OUT,
	output var  logic        RESULT_READY_N_OE,
	input  wire logic [24:0] ADC_RAW,
	output var  logic [2:0]  INPUT_SELECT,
	output var  logic        SHORT_INPUTS,
	output var  logic        GAIN_FOUR,
	output var  logic        CONVERTING,
	output var  logic        SLEEP,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output var  logic [31:0] WB_DAT_O,
	output var  logic        WB_ACK_O
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else begin
			scl_s <= {scl_s[1:0], SCL_IN};
			sda_s <= {sda_s[1:0], SDA_IN};
		end
	end
	assign scl_rise  = scl_s[1] & ~scl_s[2];
	assign scl_fall  = ~scl_s[1] & scl_s[2];
	assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
	assign bus_stop  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

	// ----------------------------------------
	// state
	// ----------------------------------------
	aics_state_t st, next_st;
	logic [2:0]  bit_cnt, next_bit_cnt;
	aics_byte_t  shreg, next_shreg;
	logic [1:0]  byte_idx, next_byte_idx;
	logic        rd_mode, next_rd_mode;
	logic        ack_on, next_ack_on;
	logic        tx_sel, next_tx_sel;
	logic [1:0]  tx_cnt, next_tx_cnt;
	logic [23:0] snap, next_snap;
	aics_byte_t  cfg, next_cfg;
	aics_byte_t  cmd, next_cmd;
	logic        running, next_running;
	logic        sleeping, next_sleeping;
	logic        pending, next_pending;
	logic [21:0] timer, next_timer;
	logic [23:0] result, next_result;
	logic [16:0] por_cnt, next_por_cnt;
	logic        por_done, next_por_done;
	logic [6:0]  dev_addr, next_dev_addr;
	logic        sda_oe, next_sda_oe;
	logic        short_in, next_short_in;
	logic        wb_ack, next_wb_ack;
	logic [31:0] wb_dat, next_wb_dat;
	logic        cmd_fire;
	logic        conv_done;
	aics_byte_t  rx_byte;
	aics_byte_t  tx_byte;

	function automatic logic [23:0] saturate(input logic [24:0] raw);
		if (!raw[24] && raw[23])
			return `AICS_CODE_MAX;
		else if (raw[24] && !raw[23])
			return `AICS_CODE_MIN;
		else
			return raw[23:0];
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st       = st;
		next_bit_cnt  = bit_cnt;
		next_shreg    = shreg;
		next_byte_idx = byte_idx;
		next_rd_mode  = rd_mode;
		next_ack_on   = ack_on;
		next_tx_sel   = tx_sel;
		next_tx_cnt   = tx_cnt;
		next_snap     = snap;
		next_cfg      = cfg;
		next_cmd      = cmd;
		next_running  = running;
		next_sleeping = sleeping;
		next_pending  = pending;
		next_timer    = timer;
		next_result   = result;
		next_por_cnt  = por_cnt;
		next_por_done = por_done;
		next_dev_addr = dev_addr;
		next_sda_oe   = sda_oe;
		next_wb_dat   = wb_dat;
		cmd_fire      = 1'b0;
		rx_byte       = {shreg[6:0], sda_s[1]};
		if (!tx_sel)
			tx_byte = (tx_cnt == 2'd0) ? cfg : `AICS_FILL_BYTE;
		else
			unique case (tx_cnt)
				2'd0: tx_byte = snap[23:16];
				2'd1: tx_byte = snap[15:8];
				2'd2: tx_byte = snap[7:0];
				default: tx_byte = `AICS_FILL_BYTE;
			endcase
		// bus ignored until internal power-on settling ends
		if (!por_done) begin
			next_por_cnt  = por_cnt + 17'd1;
			next_por_done = (por_cnt == 17'(POR_CYCLES - 1));
		end
		// wishbone: one-cycle answer, dropped the cycle after
		next_wb_ack = WB_CYC_I & WB_STB_I & ~wb_ack;
		if (next_wb_ack) begin
			next_wb_dat = 32'h0;
			unique case (WB_ADR_I)
				`AICS_REG_STATUS:  next_wb_dat = {25'h0, sleeping, running, pending, por_done, st};
				`AICS_REG_CONFIG:  next_wb_dat = {24'h0, cfg};
				`AICS_REG_RESULT:  next_wb_dat = {8'h0, result};
				`AICS_REG_DEVADDR: next_wb_dat = {25'h0, dev_addr};
				default:           next_wb_dat = 32'h0;
			endcase
			if (WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `AICS_REG_CONFIG)
				next_cfg = WB_DAT_I[7:0];
			if (WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `AICS_REG_DEVADDR)
				next_dev_addr = WB_DAT_I[6:0];
		end
		// two-wire slave; only data is ever driven, clock is input-only
		if (!por_done) begin
			next_st = AICS_IDLE;
		end else if (bus_start) begin
			next_st       = AICS_RX;
			next_bit_cnt  = 3'd0;
			next_byte_idx = 2'd0;
			next_ack_on   = 1'b0;
			next_sda_oe   = 1'b0;
		end else if (bus_stop) begin
			next_st     = AICS_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			unique case (st)
				AICS_IDLE: ;
				AICS_RX: if (scl_rise) begin
					next_shreg   = rx_byte;
					next_bit_cnt = bit_cnt + 3'd1;
					if (bit_cnt == 3'd7) begin
						next_st       = AICS_ACK;
						next_byte_idx = (byte_idx == 2'd2) ? 2'd2 : byte_idx + 2'd1;
						if (byte_idx == 2'd0) begin
							next_rd_mode = rx_byte[0];
							if (rx_byte[7:1] != dev_addr)
								next_st = AICS_IDLE;
						end else if (byte_idx == 2'd1) begin
							next_cmd = rx_byte;
							cmd_fire = 1'b1;
						end else if (cmd == `AICS_OP_CFG_WR) begin
							next_cfg = rx_byte;
						end
					end
				end
				AICS_ACK: if (scl_fall) begin
					next_ack_on = ~ack_on;
					next_sda_oe = ~ack_on;
					if (ack_on && rd_mode) begin
						next_sda_oe  = ~tx_byte[7];
						next_shreg   = tx_byte;
						next_bit_cnt = 3'd0;
						next_tx_cnt  = tx_cnt + 2'd1;
						next_st      = AICS_TX;
					end else if (ack_on) begin
						next_st = AICS_RX;
					end
				end
				AICS_LOAD: if (scl_fall) begin
					next_sda_oe = ~shreg[7];
					next_st     = AICS_TX;
				end
				AICS_TX: begin
					if (scl_rise) begin
						next_bit_cnt = bit_cnt + 3'd1;
						if (bit_cnt == 3'd7)
							next_st = AICS_MACK;
					end
					if (scl_fall) begin
						next_shreg  = {shreg[6:0], 1'b1};
						next_sda_oe = ~shreg[6];
					end
				end
				AICS_MACK: begin
					if (scl_fall)
						next_sda_oe = 1'b0;
					if (scl_rise) begin
						next_st = sda_s[1] ? AICS_IDLE : AICS_LOAD;
						next_shreg   = tx_byte;
						next_bit_cnt = 3'd0;
						next_tx_cnt  = (tx_cnt == 2'd3) ? 2'd3 : tx_cnt + 2'd1;
					end
				end
			endcase
		end
		if (cmd_fire) begin
			unique case (rx_byte)
				`AICS_OP_RESET: begin
					next_cfg      = `AICS_CFG_RST;
					next_running  = 1'b0;
					next_sleeping = 1'b0;
					next_pending  = 1'b0;
					next_timer    = 22'd0;
				end
				`AICS_OP_START: begin
					next_running  = 1'b1;
					next_sleeping = 1'b0;
					next_timer    = 22'd0;
				end
				`AICS_OP_RESULT: begin
					next_tx_sel  = 1'b1;
					next_tx_cnt  = 2'd0;
					next_snap    = result;
					next_pending = 1'b0;
				end
				`AICS_OP_CFG_RD: begin
					next_tx_sel = 1'b0;
					next_tx_cnt = 2'd0;
				end
				`AICS_OP_SLEEP: begin
					next_running  = 1'b0;
					next_sleeping = 1'b1;
				end
				default: ;
			endcase
		end
		// conversion timer; a new result beats a same-cycle read clear
		conv_done = running && timer == 22'(CONV_CYCLES - 1);
		if (conv_done) begin
			next_result  = saturate(ADC_RAW);
			next_pending = 1'b1;
		end
		// only reset, start and sleep take the timer over; other opcodes must not stall it
		if (running && !(cmd_fire && rx_byte inside {`AICS_OP_RESET, `AICS_OP_START, `AICS_OP_SLEEP})) begin
			next_timer = conv_done ? 22'd0 : timer + 22'd1;
			if (conv_done)
				next_running = cfg[`AICS_CFG_CONT];
		end
		next_short_in = (next_cfg[`AICS_CFG_SEL_HI:`AICS_CFG_SEL_LO] == `AICS_SEL_SHORT);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st       <= AICS_IDLE;
			bit_cnt  <= 3'd0;
			shreg    <= 8'h00;
			byte_idx <= 2'd0;
			rd_mode  <= 1'b0;
			ack_on   <= 1'b0;
			tx_sel   <= 1'b0;
			tx_cnt   <= 2'd0;
			snap     <= 24'h000000;
			cfg      <= `AICS_CFG_RST;
			cmd      <= 8'h00;
			running  <= 1'b0;
			sleeping <= 1'b0;
			pending  <= 1'b0;
			timer    <= 22'd0;
			result   <= 24'h000000;
			por_cnt  <= 17'd0;
			por_done <= 1'b0;
			dev_addr <= `AICS_DEVADDR_RST;
			sda_oe   <= 1'b0;
			short_in <= 1'b0;
			wb_ack   <= 1'b0;
			wb_dat   <= 32'h0;
		end else begin
			st       <= next_st;
			bit_cnt  <= next_bit_cnt;
			shreg    <= next_shreg;
			byte_idx <= next_byte_idx;
			rd_mode  <= next_rd_mode;
			ack_on   <= next_ack_on;
			tx_sel   <= next_tx_sel;
			tx_cnt   <= next_tx_cnt;
			snap     <= next_snap;
			cfg      <= next_cfg;
			cmd      <= next_cmd;
			running  <= next_running;
			sleeping <= next_sleeping;
			pending  <= next_pending;
			timer    <= next_timer;
			result   <= next_result;
			por_cnt  <= next_por_cnt;
			por_done <= next_por_done;
			dev_addr <= next_dev_addr;
			sda_oe   <= next_sda_oe;
			short_in <= next_short_in;
			wb_ack   <= next_wb_ack;
			wb_dat   <= next_wb_dat;
		end
	end

	// open-drain pins: low level only, enable marks the pull
	assign SDA_OUT            = 1'b0;
	assign SDA_OE             = sda_oe;
	assign RESULT_READY_N_OUT = 1'b0;
	assign RESULT_READY_N_OE  = pending;
	assign INPUT_SELECT       = cfg[`AICS_CFG_SEL_HI:`AICS_CFG_SEL_LO];
	assign SHORT_INPUTS       = short_in;
	assign GAIN_FOUR          = cfg[`AICS_CFG_GAIN];
	assign CONVERTING         = running;
	assign SLEEP              = sleeping;
	assign WB_DAT_O           = wb_dat;
	assign WB_ACK_O           = wb_ack;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	sequence op_seen(logic [7:0] op);
		cmd_fire && rx_byte == op;
	endsequence
	sequence wb_req;
		WB_CYC_I && WB_STB_I && !wb_ack;
	endsequence
	sequence cfg_byte_in;
		st == AICS_RX && scl_rise && bit_cnt == 3'd7 && byte_idx == 2'd2 && cmd == `AICS_OP_CFG_WR;
	endsequence
	chk_reset_op:     assert property (op_seen(`AICS_OP_RESET) |=> cfg == `AICS_CFG_RST && !running)
		else $error("reset opcode did not restore defaults");
	chk_start_runs:   assert property (op_seen(`AICS_OP_START) |=> running && !sleeping)
		else $error("start opcode did not start conversions");
	chk_sleep_halts:  assert property (op_seen(`AICS_OP_SLEEP) |=> !running && sleeping ##1 !CONVERTING)
		else $error("sleep opcode did not halt conversions");
	chk_cfg_write:    assert property (cfg_byte_in |=> cfg == $past(rx_byte))
		else $error("config write sequence broken");
	chk_ready_low:    assert property (conv_done |=> pending && RESULT_READY_N_OE)
		else $error("result ready not pulled low after conversion");
	chk_read_clears:  assert property (op_seen(`AICS_OP_RESULT) ##0 !conv_done |=> !pending && snap == $past(result))
		else $error("result read did not snapshot and release ready");
	chk_sat_pos:      assert property (conv_done && !ADC_RAW[24] && ADC_RAW[23] |=> result == `AICS_CODE_MAX)
		else $error("positive overrange not saturated");
	chk_conv_period:  assert property (timer < 22'(CONV_CYCLES))
		else $error("conversion timer overran its period");
	chk_short_mux:    assert property (SHORT_INPUTS == (INPUT_SELECT == `AICS_SEL_SHORT))
		else $error("short select not following input select");
	chk_por_quiet:    assert property (!por_done |-> !sda_oe)
		else $error("data line driven before power-on settling");
	chk_wb_answer:    assert property (wb_req |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("bus answer not a single cycle");
endmodule
`default_nettype wire

/* verif/aics_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aics_host_model
	import aics_pkg::*;
#(
	parameter int         HALF = 8,
	parameter logic [6:0] DEV  = 7'h40
) (
	input  wire logic clk,
	input  wire logic sda_line,
	output var  logic scl_pull,
	output var  logic sda_pull
);
	// ----------------------------------------
	// two-wire controller, open drain on both lines
	// ----------------------------------------
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	task automatic half();
		repeat (HALF) @(posedge clk);
	endtask
	// also used as repeated start, entered with the clock low
	task automatic start_cond();
		@(posedge clk) sda_pull <= 1'b0;
		half();
		scl_pull <= 1'b0;
		half();
		sda_pull <= 1'b1;
		half();
		scl_pull <= 1'b1;
	endtask
	task automatic stop_cond();
		@(posedge clk) sda_pull <= 1'b1;
		half();
		scl_pull <= 1'b0;
		half();
		sda_pull <= 1'b0;
		half();
	endtask
	// data moves one cycle after the clock falls, so it never looks like start or stop
	task automatic clock_bit(input logic b, output logic seen);
		@(posedge clk) sda_pull <= ~b;
		half();
		scl_pull <= 1'b0;
		half();
		seen = sda_line;
		scl_pull <= 1'b1;
	endtask
	task automatic write_byte(input aics_byte_t d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(d[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic read_byte(input logic mack, output aics_byte_t d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(1'b1, d[i]);
		clock_bit(~mack, s);
	endtask
	task automatic xfer(input aics_byte_t op, input bit has_wd, input aics_byte_t wd, input int nrd,
		output logic [23:0] rd, output logic ok);
		logic       a;
		aics_byte_t b;
		ok = 1'b1;
		rd = '0;
		start_cond();
		write_byte({DEV, 1'b0}, a);
		ok &= a;
		write_byte(op, a);
		ok &= a;
		if (has_wd) begin
			write_byte(wd, a);
			ok &= a;
		end
		if (nrd > 0) begin
			start_cond();
			write_byte({DEV, 1'b1}, a);
			ok &= a;
			for (int i = 0; i < nrd; i++) begin
				read_byte(i < nrd - 1, b);
				rd = {rd[15:0], b};
			end
		end
		stop_cond();
	endtask
endmodule
`default_nettype wire

/* verif/aics_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module aics_top_tb
	import aics_pkg::*;
();
	localparam int POR  = 20;
	localparam int CONV = 50;
	logic               clk = 1'b0;
	logic               rstn = 1'b0;
	logic               scl_pull, sda_pull, sda_oe, sda_out, rdy_out, rdy_oe;
	logic               short_in, gain, conv, slp, cyc, stb, wwe, ack;
	logic [2:0]         sel;
	logic [7:0]         adr;
	logic [31:0]        wdat, dat_o;
	logic signed [24:0] adc;
	int                 num_errors = 0;
	int                 total_checks = 0;
	wire logic          scl_line = ~scl_pull;
	wire logic          sda_line = ~sda_pull & (sda_oe ? sda_out : 1'b1);

	aics_top #(.POR_CYCLES(POR), .CONV_CYCLES(CONV)) aics_top_inst (
		.CORE_CLK(clk), .RSTN(rstn), .SCL_IN(scl_line), .SDA_IN(sda_line),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .RESULT_READY_N_OUT(rdy_out), .RESULT_READY_N_OE(rdy_oe),
		.ADC_RAW(adc), .INPUT_SELECT(sel), .SHORT_INPUTS(short_in), .GAIN_FOUR(gain),
		.CONVERTING(conv), .SLEEP(slp), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wwe),
		.WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack));
	aics_host_model aics_host_model_inst (
		.clk(clk), .sda_line(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull));

	always #2.5 clk = ~clk;
	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [23:0] sat(input logic signed [24:0] v);
		if (v > 25'sh07FFFFF)
			return 24'h7FFFFF;
		if (v < -25'sh0800000)
			return 24'h800000;
		return v[23:0];
	endfunction
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, wwe, adr, wdat} <= {2'b11, we, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		check("wb answer cycles", n, 2);
		q = dat_o;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic wbr(input logic [7:0] a, input logic [31:0] e, input string what);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		check(what, q, e);
	endtask
	task automatic i2c(input aics_byte_t op, input bit has, input aics_byte_t wd, input int nrd,
		output logic [23:0] rd);
		logic ok;
		aics_host_model_inst.xfer(op, has, wd, nrd, rd, ok);
		check("bus ack", ok, 1'b1);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_regs();
		logic [31:0] q;
		wbr(8'h04, 32'h0, "config at reset");
		wbr(8'h0C, 32'h40, "device address");
		wb(1'b1, 8'h10, 32'hFF, q);
		wbr(8'h10, 32'h0, "unmapped read");
		check("ready low level", rdy_out, 1'b0);
		check("ready idle", rdy_oe, 1'b0);
	endtask
	task automatic s_setup();
		logic [23:0] r;
		i2c(8'h06, 0, 8'h00, 0, r);
		i2c(8'h40, 1, 8'h12, 0, r);
		check("gain four", gain, 1'b1);
		check("select", sel, 3'h0);
		i2c(8'h20, 0, 8'h00, 1, r);
		check("readback", r, 24'h12);
		wbr(8'h04, 32'h12, "config");
	endtask
	task automatic s_stream();
		logic signed [24:0] raw [3] = '{25'h0FFFFFF, 25'h1000000, 25'h0123456};
		logic [23:0]        r;
		i2c(8'h08, 0, 8'h00, 0, r);
		for (int k = 0; k < 3; k++) begin
			adc <= raw[k];
			repeat (2 * CONV + 10) @(posedge clk);
			check("converting", conv, 1'b1);
			check("ready", rdy_oe, 1'b1);
			i2c(8'h10, 0, 8'h00, 3, r);
			check("result", r, sat(raw[k]));
		end
	endtask
	task automatic s_sleep();
		logic [23:0] r;
		i2c(8'h02, 0, 8'h00, 0, r);
		check("sleep", slp, 1'b1);
		check("halted", conv, 1'b0);
		repeat (2 * CONV) @(posedge clk);
		check("still halted", conv, 1'b0);
	endtask
	// two shorted readings average into the offset, which a later reading then sheds
	task automatic s_short();
		logic [23:0]        r;
		logic signed [25:0] acc;
		int                 c;
		i2c(8'h06, 0, 8'h00, 0, r);
		check("awake", slp, 1'b0);
		wbr(8'h04, 32'h0, "config after reset");
		i2c(8'h40, 1, 8'hE0, 0, r);
		check("shorted", short_in, 1'b1);
		check("select", sel, 3'h7);
		acc = '0;
		for (int k = 0; k < 3; k++) begin
			adc <= (k < 2) ? 25'h1FFFFFE : 25'h0000100;
			i2c(8'h08, 0, 8'h00, 0, r);
			c = 0;
			while (rdy_oe !== 1'b1 && c < 400) begin
				@(posedge clk);
				c++;
			end
			check("conversion time", c inside {[1:CONV]}, 1'b1);
			i2c(8'h10, 0, 8'h00, 3, r);
			check("single shot stops", conv, 1'b0);
			if (k < 2)
				acc += 26'(signed'(r));
		end
		check("offset", acc[24:1], 24'hFFFFFE);
		check("corrected", 24'(r - acc[24:1]), 24'h000102);
		wbr(8'h08, 32'h000100, "result reg");
	endtask

	initial begin
		{cyc, stb, wwe, adr, wdat} = '0;
		adc = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (POR + 10) @(posedge clk);
		s_regs();
		s_setup();
		s_stream();
		s_sleep();
		s_short();
		give_verdict();
	end
	// well above the roughly eleven thousand cycles the scenarios need
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
